// ### design/bcd_match.sv
// one alarm comparison: enable from bit 7, value against current time
module bcd_match #(
   parameter int WIDTH = 7
) (
   input wire logic [7:0] match_reg,
   input wire logic [WIDTH-1:0] current,
   output logic enabled,
   output logic hit
);
   if (WIDTH < 1 || WIDTH > 7)
   begin : g_bad_width
      $error("bcd_match width must be 1 to 7");
   end

   // unused upper bits take no part in the compare
   assign enabled = ~match_reg[rtc_alarm_pkg::MATCH_DIS_BIT];
   assign hit = (match_reg[WIDTH-1:0] == current);
endmodule

// ### design/rate_divider.sv
// divides a stream of enable pulses by a fixed ratio
module rate_divider #(
   parameter int DIV = 60
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic step,
   output logic pulse
);
   localparam int CW = $clog2(DIV);
   localparam logic [CW-1:0] LAST = CW'(DIV - 1);
   logic [CW-1:0] cnt;
   logic [CW-1:0] next_cnt;

   if (DIV < 2)
   begin : g_bad_div
      $error("rate_divider needs DIV of at least 2");
   end

   assign pulse = step && (cnt == LAST);

   always_comb
   begin
      next_cnt = cnt;
      if (pulse)
         next_cnt = '0;
      else if (step)
         next_cnt = cnt + CW'(1);
   end

   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
         cnt <= '0;
      else
         cnt <= next_cnt;
   end
endmodule

// ### design/rtc_alarm_timer_interrupt.sv
// alarm compare, countdown timer, interrupt pin and two-wire register port
// Overview of operation
// - compare each enabled alarm with current time
// - bit 7 disables compare, reset value one
// - minute alarm: tens bits 6-4, units 3-0
// - hour alarm: tens bits 5-4, units 3-0
// - day alarm: tens bits 5-4, units 3-0
// - weekday alarm: value 0-6 in bits 2-0
// - all enabled matches set sticky alarm flag
// - re-set only on new match, not persistence
// - disabled alarms ignored; none enabled, no match
// - flag write keeps old AND written bit
// - alarm flag bit 3, timer flag bit 2
// - 8-bit down-counter sets timer flag each end
// - run bit 7 enables countdown, default off
// - bits 1-0 select 4096, 64, 1, 1/60 Hz
// - reading counter returns live count
// - mode bit: pulse per period or level
// - separate enables gate flags, ORed onto pin
// - pulse width depends on clock and count
// - loaded zero keeps timer stopped, no events
// - period equals count over source frequency
module rtc_alarm_timer_interrupt #(
   parameter int TICK_DIV = rtc_alarm_pkg::BASE_TICK_DIV,
   parameter logic [6:0] DEV_ADDR = rtc_alarm_pkg::DEV_ADDR_DEFAULT
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic scl,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   input wire logic [6:0] cur_minute,
   input wire logic [5:0] cur_hour,
   input wire logic [5:0] cur_day,
   input wire logic [2:0] cur_weekday,
   output logic irq_n_out,
   output logic irq_n_oe
);
   typedef enum logic [3:0] {
      ST_IDLE, ST_ADDR, ST_ACK_ADDR, ST_WORD, ST_ACK_WORD,
      ST_WRITE, ST_ACK_WRITE, ST_READ, ST_READ_ACK
   } bus_state_t;

   // serial port state
   bus_state_t state, next_state;
   logic [3:0] bit_cnt, next_bit_cnt;
   logic [7:0] shreg, next_shreg;
   logic [3:0] ptr, next_ptr;
   logic next_sda_oe;
   logic scl_q, sda_q;
   logic scl_rise, scl_fall, start_c, stop_c;
   logic wr_en;
   logic [3:0] wr_addr;
   logic [7:0] wr_data, rd_data;

   // registers and timer state
   logic [7:0] minute_match_value, hour_match_value, day_match_value, weekday_match_value;
   logic [7:0] next_minute_match_value, next_hour_match_value;
   logic [7:0] next_day_match_value, next_weekday_match_value;
   logic countdown_run, next_countdown_run;
   logic [1:0] countdown_clock_select, next_countdown_clock_select;
   logic [7:0] reload, next_reload, count, next_count;
   logic alarm_flag, next_alarm_flag, timer_flag, next_timer_flag;
   logic irq_pulse_mode, next_irq_pulse_mode;
   logic alarm_irq_enable, next_alarm_irq_enable;
   logic timer_irq_enable, next_timer_irq_enable;
   logic match_prev;
   logic [7:0] pulse_left, next_pulse_left, pulse_width;
   logic [rtc_alarm_pkg::PRESCALE_W-1:0] pre, next_pre;
   logic next_irq_n_oe;

   logic base_tick, tick_60th, src_tick, tf_set, af_set, alarm_match, value_wr;
   logic [3:0] match_en, match_hit;

   if (TICK_DIV < 2)
   begin : g_bad_tick
      $error("TICK_DIV must be at least 2");
   end

   // clock enables: base 8192 Hz, then binary prescaler
   rate_divider #(.DIV(TICK_DIV)) base_div (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .step(1'b1),
      .pulse(base_tick)
   );

   rate_divider #(.DIV(rtc_alarm_pkg::SLOW_DIV)) slow_div (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .step(base_tick && (&pre)),
      .pulse(tick_60th)
   );

   always_comb
   begin
      unique case (rtc_alarm_pkg::clk_sel_t'(countdown_clock_select))
         rtc_alarm_pkg::SEL_4096HZ: src_tick = base_tick && pre[0];
         rtc_alarm_pkg::SEL_64HZ: src_tick = base_tick && (&pre[6:0]);
         rtc_alarm_pkg::SEL_1HZ: src_tick = base_tick && (&pre);
         rtc_alarm_pkg::SEL_60TH_HZ: src_tick = tick_60th;
      endcase
   end

   // alarm comparisons
   bcd_match #(.WIDTH(rtc_alarm_pkg::MINUTE_W)) minute_cmp (
      .match_reg(minute_match_value),
      .current(cur_minute),
      .enabled(match_en[0]),
      .hit(match_hit[0])
   );
   bcd_match #(.WIDTH(rtc_alarm_pkg::HOUR_W)) hour_cmp (
      .match_reg(hour_match_value),
      .current(cur_hour),
      .enabled(match_en[1]),
      .hit(match_hit[1])
   );
   bcd_match #(.WIDTH(rtc_alarm_pkg::DAY_W)) day_cmp (
      .match_reg(day_match_value),
      .current(cur_day),
      .enabled(match_en[2]),
      .hit(match_hit[2])
   );
   bcd_match #(.WIDTH(rtc_alarm_pkg::WEEKDAY_W)) weekday_cmp (
      .match_reg(weekday_match_value),
      .current(cur_weekday),
      .enabled(match_en[3]),
      .hit(match_hit[3])
   );

   assign alarm_match = (|match_en) && (&(~match_en | match_hit));
   // edge of the match, so a standing match cannot re-arm the flag
   assign af_set = alarm_match && !match_prev;

   // start and stop seen only while the clock line is high
   assign scl_rise = scl && !scl_q;
   assign scl_fall = !scl && scl_q;
   assign start_c = scl && scl_q && sda_q && !sda_in;
   assign stop_c = scl && scl_q && !sda_q && sda_in;

   always_comb
   begin
      rd_data = 8'h00;
      unique case (ptr)
         rtc_alarm_pkg::ADDR_FLAGS: rd_data = {3'h0, irq_pulse_mode, alarm_flag, timer_flag,
            alarm_irq_enable, timer_irq_enable};
         rtc_alarm_pkg::ADDR_MINUTE: rd_data = minute_match_value;
         rtc_alarm_pkg::ADDR_HOUR: rd_data = {hour_match_value[7], 1'b0, hour_match_value[5:0]};
         rtc_alarm_pkg::ADDR_DAY: rd_data = {day_match_value[7], 1'b0, day_match_value[5:0]};
         rtc_alarm_pkg::ADDR_WEEKDAY: rd_data = {weekday_match_value[7], 4'h0,
            weekday_match_value[2:0]};
         rtc_alarm_pkg::ADDR_CONFIG: rd_data = {countdown_run, 5'h00, countdown_clock_select};
         rtc_alarm_pkg::ADDR_VALUE: rd_data = count;
         default: rd_data = 8'h00;
      endcase
   end

   // serial slave: data sampled on clock rise, driven after clock fall
   always_comb
   begin
      next_state = state;
      next_bit_cnt = bit_cnt;
      next_shreg = shreg;
      next_ptr = ptr;
      next_sda_oe = sda_oe;
      wr_en = 1'b0;
      wr_addr = ptr;
      wr_data = shreg;
      if (start_c)
      begin
         next_state = ST_ADDR;
         next_bit_cnt = 4'h0;
         next_sda_oe = 1'b0;
      end
      else if (stop_c)
      begin
         next_state = ST_IDLE;
         next_sda_oe = 1'b0;
      end
      else
      begin
         unique case (state)
            ST_IDLE: next_state = ST_IDLE;
            ST_ADDR, ST_WORD, ST_WRITE:
            begin
               if (scl_rise)
               begin
                  next_shreg = {shreg[6:0], sda_in};
                  next_bit_cnt = bit_cnt + 4'h1;
               end
               else if (scl_fall && bit_cnt == 4'h8)
               begin
                  next_bit_cnt = 4'h0;
                  next_sda_oe = 1'b1;
                  if (state == ST_ADDR)
                  begin
                     next_sda_oe = (shreg[7:1] == DEV_ADDR);
                     next_state = next_sda_oe ? ST_ACK_ADDR : ST_IDLE;
                  end
                  else if (state == ST_WORD)
                  begin
                     next_ptr = shreg[3:0];
                     next_state = ST_ACK_WORD;
                  end
                  else
                  begin
                     wr_en = 1'b1;
                     next_ptr = ptr + 4'h1;
                     next_state = ST_ACK_WRITE;
                  end
               end
            end
            ST_ACK_ADDR:
            begin
               if (scl_fall && shreg[0])
               begin
                  next_shreg = rd_data;
                  next_sda_oe = !rd_data[7];
                  next_state = ST_READ;
               end
               else if (scl_fall)
               begin
                  next_sda_oe = 1'b0;
                  next_state = ST_WORD;
               end
            end
            ST_ACK_WORD, ST_ACK_WRITE:
            begin
               if (scl_fall)
               begin
                  next_sda_oe = 1'b0;
                  next_state = ST_WRITE;
               end
            end
            ST_READ:
            begin
               if (scl_fall && bit_cnt == 4'h7)
               begin
                  next_sda_oe = 1'b0;
                  next_bit_cnt = 4'h0;
                  next_ptr = ptr + 4'h1;
                  next_state = ST_READ_ACK;
               end
               else if (scl_fall)
               begin
                  next_shreg = {shreg[6:0], 1'b0};
                  next_sda_oe = !shreg[6];
                  next_bit_cnt = bit_cnt + 4'h1;
               end
            end
            ST_READ_ACK:
            begin
               if (scl_rise && sda_in)
                  next_state = ST_IDLE;
               else if (scl_rise)
                  next_bit_cnt = 4'h8;
               else if (scl_fall && bit_cnt == 4'h8)
               begin
                  next_shreg = rd_data;
                  next_sda_oe = !rd_data[7];
                  next_bit_cnt = 4'h0;
                  next_state = ST_READ;
               end
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         state <= ST_IDLE;
         bit_cnt <= 4'h0;
         shreg <= 8'h00;
         ptr <= 4'h0;
         sda_oe <= 1'b0;
         sda_out <= 1'b0;
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end
      else
      begin
         state <= next_state;
         bit_cnt <= next_bit_cnt;
         shreg <= next_shreg;
         ptr <= next_ptr;
         sda_oe <= next_sda_oe;
         sda_out <= 1'b0;
         scl_q <= scl;
         sda_q <= sda_in;
      end
   end

   assign value_wr = wr_en && (wr_addr == rtc_alarm_pkg::ADDR_VALUE);

   // interrupt pulse length in base ticks
   always_comb
   begin
      if (countdown_clock_select == rtc_alarm_pkg::SEL_4096HZ)
         pulse_width = (reload == 8'h01) ? rtc_alarm_pkg::PW_8192TH
            : rtc_alarm_pkg::PW_4096TH;
      else if (countdown_clock_select == rtc_alarm_pkg::SEL_64HZ && reload == 8'h01)
         pulse_width = rtc_alarm_pkg::PW_128TH;
      else
         pulse_width = rtc_alarm_pkg::PW_64TH;
   end

   // registers, countdown, flags and pin
   always_comb
   begin
      next_minute_match_value = minute_match_value;
      next_hour_match_value = hour_match_value;
      next_day_match_value = day_match_value;
      next_weekday_match_value = weekday_match_value;
      next_countdown_run = countdown_run;
      next_countdown_clock_select = countdown_clock_select;
      next_irq_pulse_mode = irq_pulse_mode;
      next_alarm_irq_enable = alarm_irq_enable;
      next_timer_irq_enable = timer_irq_enable;
      next_reload = reload;
      next_count = count;
      next_pre = base_tick ? pre + {{(rtc_alarm_pkg::PRESCALE_W - 1){1'b0}}, 1'b1} : pre;
      tf_set = 1'b0;
      if (wr_en)
      begin
         unique case (wr_addr)
            rtc_alarm_pkg::ADDR_MINUTE: next_minute_match_value = wr_data;
            rtc_alarm_pkg::ADDR_HOUR: next_hour_match_value = wr_data;
            rtc_alarm_pkg::ADDR_DAY: next_day_match_value = wr_data;
            rtc_alarm_pkg::ADDR_WEEKDAY: next_weekday_match_value = wr_data;
            rtc_alarm_pkg::ADDR_CONFIG:
            begin
               next_countdown_run = wr_data[rtc_alarm_pkg::RUN_BIT];
               next_countdown_clock_select = wr_data[1:0];
            end
            rtc_alarm_pkg::ADDR_FLAGS:
            begin
               next_irq_pulse_mode = wr_data[rtc_alarm_pkg::PULSE_MODE_BIT];
               next_alarm_irq_enable = wr_data[rtc_alarm_pkg::ALARM_IE_BIT];
               next_timer_irq_enable = wr_data[rtc_alarm_pkg::TIMER_IE_BIT];
            end
            default: next_reload = reload;
         endcase
      end
      if (value_wr)
      begin
         next_reload = wr_data;
         next_count = wr_data;
      end
      else if (countdown_run && reload != 8'h00 && src_tick)
      begin
         // n source ticks from load to flag, then reload
         if (count <= 8'h01)
         begin
            next_count = reload;
            tf_set = 1'b1;
         end
         else
            next_count = count - 8'h01;
      end
      // a set in the same cycle as a clearing write wins
      next_alarm_flag = af_set || alarm_flag;
      next_timer_flag = tf_set || timer_flag;
      if (wr_en && wr_addr == rtc_alarm_pkg::ADDR_FLAGS)
      begin
         next_alarm_flag = af_set || (alarm_flag && wr_data[rtc_alarm_pkg::ALARM_FLAG_BIT]);
         next_timer_flag = tf_set || (timer_flag && wr_data[rtc_alarm_pkg::TIMER_FLAG_BIT]);
      end
      next_pulse_left = pulse_left;
      if (tf_set)
         next_pulse_left = pulse_width;
      else if (base_tick && pulse_left != 8'h00)
         next_pulse_left = pulse_left - 8'h01;
      next_irq_n_oe = (alarm_flag && alarm_irq_enable) || (timer_irq_enable &&
         (irq_pulse_mode ? (pulse_left != 8'h00) : timer_flag));
   end

   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         minute_match_value <= rtc_alarm_pkg::MATCH_RESET;
         hour_match_value <= rtc_alarm_pkg::MATCH_RESET;
         day_match_value <= rtc_alarm_pkg::MATCH_RESET;
         weekday_match_value <= rtc_alarm_pkg::MATCH_RESET;
         countdown_run <= 1'b0;
         countdown_clock_select <= rtc_alarm_pkg::SEL_RESET;
         irq_pulse_mode <= 1'b0;
         alarm_irq_enable <= 1'b0;
         timer_irq_enable <= 1'b0;
         reload <= rtc_alarm_pkg::VALUE_RESET;
         count <= rtc_alarm_pkg::VALUE_RESET;
         pre <= '0;
         alarm_flag <= 1'b0;
         timer_flag <= 1'b0;
         match_prev <= 1'b0;
         pulse_left <= 8'h00;
         irq_n_oe <= 1'b0;
         irq_n_out <= 1'b0;
      end
      else
      begin
         minute_match_value <= next_minute_match_value;
         hour_match_value <= next_hour_match_value;
         day_match_value <= next_day_match_value;
         weekday_match_value <= next_weekday_match_value;
         countdown_run <= next_countdown_run;
         countdown_clock_select <= next_countdown_clock_select;
         irq_pulse_mode <= next_irq_pulse_mode;
         alarm_irq_enable <= next_alarm_irq_enable;
         timer_irq_enable <= next_timer_irq_enable;
         reload <= next_reload;
         count <= next_count;
         pre <= next_pre;
         alarm_flag <= next_alarm_flag;
         timer_flag <= next_timer_flag;
         match_prev <= alarm_match;
         pulse_left <= next_pulse_left;
         irq_n_oe <= next_irq_n_oe;
         irq_n_out <= 1'b0;
      end
   end

   AST_ALARM_SET: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (alarm_match && !match_prev) |=> alarm_flag)
      else $error("alarm flag not set on new match");
   AST_NO_REARM: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (!alarm_flag && alarm_match && match_prev) |=> !alarm_flag)
      else $error("alarm flag re-set by a standing match");
   AST_NONE_ENABLED: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (&{minute_match_value[7], hour_match_value[7], day_match_value[7],
      weekday_match_value[7]}) |-> !alarm_match)
      else $error("match with every compare disabled");
   AST_AND_CLEAR: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (wr_en && wr_addr == rtc_alarm_pkg::ADDR_FLAGS && !wr_data[3] && !af_set)
      |=> !alarm_flag)
      else $error("alarm flag survived a zero write");
   AST_AND_KEEP: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (wr_en && wr_addr == rtc_alarm_pkg::ADDR_FLAGS && wr_data[2] && timer_flag)
      |=> timer_flag)
      else $error("timer flag lost on a one write");
   AST_ZERO_STOPS: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (reload == 8'h00 && !value_wr) |=> (!timer_flag || $past(timer_flag)) && $stable(count))
      else $error("timer ran with zero loaded");
   AST_RELOAD: assert property (@(posedge sys_clk) disable iff (!rst_n)
      tf_set |=> (count == $past(reload)) && timer_flag)
      else $error("countdown end did not reload and flag");
   AST_STEP: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (countdown_run && src_tick && count > 8'h01 && reload != 8'h00 && !value_wr)
      |=> count == $past(count) - 8'h01)
      else $error("countdown did not step by one");
   AST_HALTED: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (!countdown_run && !value_wr) |=> $stable(count))
      else $error("count moved while disabled");
   AST_PULSE_LEN: assert property (@(posedge sys_clk) disable iff (!rst_n)
      tf_set |=> pulse_left == $past(pulse_width))
      else $error("pulse length not loaded");
   AST_LEVEL_PIN: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (!irq_pulse_mode && timer_irq_enable && timer_flag) |=> irq_n_oe)
      else $error("level interrupt not driven");
   AST_GATED_OFF: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (!alarm_irq_enable && !timer_irq_enable) |=> !irq_n_oe)
      else $error("interrupt driven with both enables off");
   AST_LIVE_READ: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (ptr == rtc_alarm_pkg::ADDR_VALUE) |-> rd_data == count)
      else $error("counter read does not return live count");
endmodule

// ### dv/bus_host.sv
// two-wire host model driving the register port
module bus_host (
   input wire logic sys_clk,
   input wire logic sda_oe,
   output logic scl,
   output logic sda_in
);
   timeunit 1ns;
   timeprecision 1ps;
   logic drv = 1'b1;
   logic [6:0] dev = rtc_alarm_pkg::DEV_ADDR_DEFAULT;
   // pull-up: line high unless someone pulls low
   assign sda_in = drv & ~sda_oe;
   initial scl = 1'b1;
   task automatic hw(input int n);
      repeat (n) @(negedge sys_clk);
   endtask
   // 14-clock bit; count read back only at 64 Hz, far below half the bit rate
   task automatic bitx(input logic b, output logic r);
      drv = b;
      hw(6);
      scl = 1'b1;
      hw(6);
      r = sda_in;
      scl = 1'b0;
      hw(2);
   endtask
   task automatic start();
      drv = 1'b1;
      hw(3);
      scl = 1'b1;
      hw(6);
      drv = 1'b0;
      hw(6);
      scl = 1'b0;
      hw(2);
   endtask
   task automatic stop();
      drv = 1'b0;
      hw(3);
      scl = 1'b1;
      hw(6);
      drv = 1'b1;
      hw(6);
   endtask
   task automatic bytex(input logic [7:0] d, input logic l, output logic [7:0] q,
                        inout logic ok);
      logic a;
      for (int i = 7; i >= 0; i--)
         bitx(d[i], q[i]);
      bitx(l, a);
      ok = ok & ~a;
   endtask
   task automatic wr_reg(input logic [3:0] a, input logic [7:0] d, output logic ok);
      logic [7:0] q;
      ok = 1'b1;
      start();
      bytex({dev, 1'b0}, 1'b1, q, ok);
      bytex({4'h0, a}, 1'b1, q, ok);
      bytex(d, 1'b1, q, ok);
      stop();
   endtask
   task automatic rd_reg(input logic [3:0] a, output logic [7:0] q, output logic ok);
      logic n;
      ok = 1'b1;
      n = 1'b1;
      start();
      bytex({dev, 1'b0}, 1'b1, q, ok);
      bytex({4'h0, a}, 1'b1, q, ok);
      start();
      bytex({dev, 1'b1}, 1'b1, q, ok);
      // nack ends the read
      bytex(8'hff, 1'b1, q, n);
      stop();
   endtask
endmodule

// ### dv/tb_rtc_alarm_timer_interrupt.sv
// self-checking bench for alarm, countdown and interrupt block
module tb_rtc_alarm_timer_interrupt;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic scl, sda_in, sda_out, sda_oe, irq_n_out, irq_n_oe, ok;
   logic [6:0] cur_minute = 7'h00;
   logic [5:0] cur_hour = 6'h00;
   logic [5:0] cur_day = 6'h00;
   logic [2:0] cur_weekday = 3'h0;
   logic [7:0] q, q2;
   int num_errors = 0;
   int checks = 0;
   initial forever #2 sys_clk = ~sys_clk;
   rtc_alarm_timer_interrupt #(.TICK_DIV(4)) rtc_alarm_timer_interrupt_i (.sys_clk(sys_clk),
      .rst_n(rst_n), .scl(scl), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
      .cur_minute(cur_minute), .cur_hour(cur_hour), .cur_day(cur_day),
      .cur_weekday(cur_weekday), .irq_n_out(irq_n_out), .irq_n_oe(irq_n_oe));
   bus_host bus_host_i (.sys_clk(sys_clk), .sda_oe(sda_oe), .scl(scl), .sda_in(sda_in));
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      checks++;
      if (g !== e)
      begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      bus_host_i.wr_reg(a, d, ok);
   endtask
   task automatic rc(input logic [3:0] a, input logic [7:0] e);
      bus_host_i.rd_reg(a, q, ok);
      chk($sformatf("reg %h", a), e, q);
   endtask
   task automatic t_regs();
      for (int a = 9; a < 13; a++)
         rc(4'(a), 8'h80);
      rc(4'he, 8'h03);
      rc(4'h1, 8'h00);
      rc(4'h2, 8'h00);
      bus_host_i.dev = ~rtc_alarm_pkg::DEV_ADDR_DEFAULT;
      wr(4'h9, 8'h00);
      chk("ack", 8'h00, {7'h0, ok});
      bus_host_i.dev = rtc_alarm_pkg::DEV_ADDR_DEFAULT;
      rc(4'h9, 8'h80);
      for (int s = 0; s < 4; s++)
      begin
         wr(4'he, 8'(s));
         rc(4'he, 8'(s));
      end
   endtask
   task automatic t_alarm();
      cur_minute = 7'h45;
      cur_hour = 6'h12;
      cur_day = 6'h31;
      cur_weekday = 3'h6;
      wr(4'h1, 8'h02);
      rc(4'h1, 8'h02);
      wr(4'ha, 8'h53);
      wr(4'h9, 8'h45);
      wr(4'hb, 8'h71);
      wr(4'hc, 8'h7e);
      rc(4'h1, 8'h02);
      wr(4'ha, 8'h52);
      rc(4'h1, 8'h0a);
      chk("irq", 8'h01, {7'h0, irq_n_oe});
      chk("pin levels", 8'h00, {6'h0, sda_out, irq_n_out});
      rc(4'ha, 8'h12);
      rc(4'hb, 8'h31);
      rc(4'hc, 8'h06);
      rc(4'h9, 8'h45);
      wr(4'h1, 8'he6);
      rc(4'h1, 8'h02);
      chk("irq", 8'h00, {7'h0, irq_n_oe});
      cur_minute = 7'h46;
      repeat (4) @(negedge sys_clk);
      cur_minute = 7'h45;
      rc(4'h1, 8'h0a);
   endtask
   task automatic wl(input logic v);
      for (int i = 0; i < 300 && irq_n_oe !== v; i++)
         @(negedge sys_clk);
   endtask
   task automatic t_pulse(input logic [7:0] n, input int wmin, input int wmax);
      int w;
      int p;
      wr(4'hf, n);
      wl(1'b1);
      wl(1'b0);
      wl(1'b1);
      for (w = 0; w < 300 && irq_n_oe === 1'b1; w++)
         @(negedge sys_clk);
      for (p = w; p < 300 && irq_n_oe !== 1'b1; p++)
         @(negedge sys_clk);
      chk("width ok", 8'h01, {7'h0, w >= wmin && w <= wmax});
      chk("period", 8'(n * 8), 8'(p));
   endtask
   task automatic t_timer();
      wr(4'h1, 8'h01);
      wr(4'hf, 8'h03);
      wr(4'he, 8'h80);
      repeat (30) @(negedge sys_clk);
      chk("irq", 8'h01, {7'h0, irq_n_oe});
      wr(4'he, 8'h00);
      rc(4'h1, 8'h05);
      wr(4'h1, 8'h09);
      rc(4'h1, 8'h01);
      chk("irq", 8'h00, {7'h0, irq_n_oe});
      wr(4'hf, 8'h00);
      wr(4'he, 8'h80);
      repeat (100) @(negedge sys_clk);
      rc(4'h1, 8'h01);
      wr(4'h1, 8'h11);
      t_pulse(8'h03, 4, 8);
      t_pulse(8'h01, 1, 4);
      wr(4'he, 8'h81);
      wr(4'hf, 8'hc8);
      // a full 64 Hz period, so the first read already sees one step
      repeat (520) @(negedge sys_clk);
      bus_host_i.rd_reg(4'hf, q2, ok);
      bus_host_i.rd_reg(4'hf, q, ok);
      chk("live", 8'h01, {7'h0, q < q2 && q2 < 8'hc8});
   endtask
   task automatic tally_and_finish();
      $display("checks %0d errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   initial
   begin
      repeat (4) @(negedge sys_clk);
      rst_n = 1'b1;
      repeat (2) @(negedge sys_clk);
      t_regs();
      t_alarm();
      t_timer();
      tally_and_finish();
   end
   // fifty bus accesses of 410 to 553 clocks each
   initial
   begin
      #400us;
      num_errors++;
      tally_and_finish();
   end
endmodule

// ### shared/rtc_alarm_pkg.sv
// shared constants for the alarm, countdown and interrupt block
package rtc_alarm_pkg;
   localparam int SYS_CLK_HZ = 250_000_000;
   localparam int BASE_TICK_HZ = 8192;
   localparam int BASE_TICK_DIV = (SYS_CLK_HZ + BASE_TICK_HZ / 2) / BASE_TICK_HZ;
   localparam int PRESCALE_W = 13;
   localparam int SLOW_DIV = 60;
   localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h2a; // arbitrary value
   // register word addresses
   localparam logic [3:0] ADDR_FLAGS = 4'h1;
   localparam logic [3:0] ADDR_MINUTE = 4'h9;
   localparam logic [3:0] ADDR_HOUR = 4'ha;
   localparam logic [3:0] ADDR_DAY = 4'hb;
   localparam logic [3:0] ADDR_WEEKDAY = 4'hc;
   localparam logic [3:0] ADDR_CONFIG = 4'he;
   localparam logic [3:0] ADDR_VALUE = 4'hf;
   // field positions
   localparam int MATCH_DIS_BIT = 7;
   localparam int RUN_BIT = 7;
   localparam int ALARM_FLAG_BIT = 3;
   localparam int TIMER_FLAG_BIT = 2;
   localparam int PULSE_MODE_BIT = 4;
   localparam int ALARM_IE_BIT = 1;
   localparam int TIMER_IE_BIT = 0;
   localparam int MINUTE_W = 7;
   localparam int HOUR_W = 6;
   localparam int DAY_W = 6;
   localparam int WEEKDAY_W = 3;
   // reset values
   localparam logic [7:0] MATCH_RESET = 8'h80;
   localparam logic [1:0] SEL_RESET = 2'h3;
   localparam logic [7:0] VALUE_RESET = 8'h00;
   // pulse widths in base ticks
   localparam logic [7:0] PW_8192TH = 8'(BASE_TICK_HZ / 8192);
   localparam logic [7:0] PW_4096TH = 8'(BASE_TICK_HZ / 4096);
   localparam logic [7:0] PW_128TH = 8'(BASE_TICK_HZ / 128);
   localparam logic [7:0] PW_64TH = 8'(BASE_TICK_HZ / 64);
   typedef enum logic [1:0] {
      SEL_4096HZ = 2'h0,
      SEL_64HZ = 2'h1,
      SEL_1HZ = 2'h2,
      SEL_60TH_HZ = 2'h3
   } clk_sel_t;
endpackage
